// File: rtl/cid_pkg.sv
// Package of constants for the cache identification register bank.
package cid_pkg;
	// ****************************************
	// Addresses.
	// ****************************************
	localparam logic [31:0] ADDR_LEVEL_ID = 32'hE000ED78;
	localparam logic [31:0] ADDR_TYPE_INFO = 32'hE000ED7C;
	localparam logic [31:0] ADDR_SIZE_ID = 32'hE000ED80;
	localparam logic [31:0] ADDR_SIZE_SELECT = 32'hE000ED84;
	// ****************************************
	// Fixed values and fields.
	// ****************************************
	localparam logic [31:0] LEVEL_ID_RESET = 32'h09000003;
	localparam logic [31:0] TYPE_INFO_VALUE = 32'h8303C003;
	localparam logic [2:0] LEVEL_PRESENT = 3'h1;
	localparam int LVL_UNIFY_LSB = 27;
	localparam int LVL_COHERE_LSB = 24;
	localparam int LVL_DCACHE_BIT = 1;
	localparam int LVL_ICACHE_BIT = 0;
	localparam int SEL_INSTR_BIT = 0;
	localparam int SIZE_SETS_LSB = 13;
	localparam int SIZE_WAYS_LSB = 3;
	localparam logic [3:0] SIZE_ATTR = 4'hF;
	localparam logic [14:0] D_SETS_M1 = 15'h00FF;
	localparam logic [9:0] D_WAYS_M1 = 10'h003;
	localparam logic [14:0] I_SETS_M1 = 15'h00FF;
	localparam logic [9:0] I_WAYS_M1 = 10'h001;
	localparam logic [2:0] LINE_CODE = 3'h1;
	localparam logic SELECT_RESET = 1'h0;
endpackage

// File: rtl/cid_regs.sv
// Cache identification register bank on the privileged system path.
`timescale 1ns/1ps
module cid_regs (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clk_en,
	// Configuration
	input wire logic dcache_present,
	input wire logic icache_present,
	// Access port
	input wire logic acc_valid,
	input wire logic acc_write,
	input wire logic acc_priv,
	input wire logic [31:0] acc_addr,
	input wire logic [31:0] acc_wdata,
	// Answer
	output logic acc_done,
	output logic bus_error_exception,
	output logic [31:0] acc_rdata
);
	typedef struct packed {
		logic instr_sel;
		logic done;
		logic err;
		logic [31:0] rdata;
	} cid_state_t;

	cid_state_t st_reg;
	cid_state_t st_next;
	logic [31:0] size_word;
	logic [31:0] level_word;
	logic any_cache;

	cid_size_mux u_size (
		.instr_sel(st_reg.instr_sel),
		.dcache_present(dcache_present),
		.icache_present(icache_present),
		.size_word(size_word)
	);

	// ****************************************
	// Level word.
	// ****************************************
	assign any_cache = dcache_present | icache_present;
	always_comb begin
		level_word = 32'h00000000;
		level_word[cid_pkg::LVL_UNIFY_LSB +: 3] = any_cache ? cid_pkg::LEVEL_PRESENT : 3'h0;
		level_word[cid_pkg::LVL_COHERE_LSB +: 3] = any_cache ? cid_pkg::LEVEL_PRESENT : 3'h0;
		level_word[cid_pkg::LVL_DCACHE_BIT] = dcache_present;
		level_word[cid_pkg::LVL_ICACHE_BIT] = icache_present;
	end

	// ****************************************
	// Access handling.
	// ****************************************
	always_comb begin
		st_next = st_reg;
		st_next.done = 1'h0;
		st_next.err = 1'h0;
		if (acc_valid) begin
			if (!acc_priv) begin
				st_next.err = 1'h1;
				st_next.rdata = 32'h00000000;
			end else begin
				st_next.done = 1'h1;
				st_next.rdata = 32'h00000000;
				if (!acc_write) begin
					unique case (acc_addr)
						cid_pkg::ADDR_LEVEL_ID: st_next.rdata = level_word;
						cid_pkg::ADDR_TYPE_INFO: st_next.rdata = cid_pkg::TYPE_INFO_VALUE;
						cid_pkg::ADDR_SIZE_ID: st_next.rdata = size_word;
						cid_pkg::ADDR_SIZE_SELECT: st_next.rdata = {31'h0, st_reg.instr_sel};
						default: st_next.rdata = 32'h00000000;
					endcase
				end else if (acc_addr == cid_pkg::ADDR_SIZE_SELECT) begin
					st_next.instr_sel = acc_wdata[cid_pkg::SEL_INSTR_BIT];
				end
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_reg <= '0;
		end else if (clk_en) begin
			st_reg <= st_next;
		end
	end

	assign acc_done = st_reg.done;
	assign bus_error_exception = st_reg.err;
	assign acc_rdata = st_reg.rdata;

	// ****************************************
	// Checks.
	// ****************************************
	property p_unpriv_err;
		@(posedge sys_clk) disable iff (rst)
		(clk_en && acc_valid && !acc_priv) |=> (bus_error_exception && !acc_done);
	endproperty
	a_unpriv_err: assert property (p_unpriv_err) else $error("unprivileged access not faulted");
	property p_priv_done;
		@(posedge sys_clk) disable iff (rst)
		(clk_en && acc_valid && acc_priv) |=> (acc_done && !bus_error_exception);
	endproperty
	a_priv_done: assert property (p_priv_done) else $error("privileged access not done");
	property p_level_read;
		@(posedge sys_clk) disable iff (rst)
		(clk_en && acc_valid && acc_priv && !acc_write && acc_addr == cid_pkg::ADDR_LEVEL_ID
			&& dcache_present && icache_present) |=> (acc_rdata == cid_pkg::LEVEL_ID_RESET);
	endproperty
	a_level_read: assert property (p_level_read) else $error("level word wrong");
	property p_type_read;
		@(posedge sys_clk) disable iff (rst)
		(clk_en && acc_valid && acc_priv && !acc_write && acc_addr == cid_pkg::ADDR_TYPE_INFO)
			|=> (acc_rdata == 32'h8303C003);
	endproperty
	a_type_read: assert property (p_type_read) else $error("type word wrong");
	property p_no_cache_level;
		@(posedge sys_clk) disable iff (rst)
		(!dcache_present && !icache_present) |-> (level_word == 32'h00000000);
	endproperty
	a_no_cache_level: assert property (p_no_cache_level) else $error("level not zero");
	property p_absent_zero;
		@(posedge sys_clk) disable iff (rst)
		(st_reg.instr_sel ? !icache_present : !dcache_present) |-> (size_word == 32'h00000000);
	endproperty
	a_absent_zero: assert property (p_absent_zero) else $error("absent size not zero");
	property p_sel_write;
		@(posedge sys_clk) disable iff (rst)
		(clk_en && acc_valid && acc_priv && acc_write && acc_addr == cid_pkg::ADDR_SIZE_SELECT)
			|=> (st_reg.instr_sel == $past(acc_wdata[0]));
	endproperty
	a_sel_write: assert property (p_sel_write) else $error("selection not stored");
	property p_size_geom;
		@(posedge sys_clk) disable iff (rst)
		(!st_reg.instr_sel && dcache_present) |-> (size_word == 32'hF01FE019);
	endproperty
	a_size_geom: assert property (p_size_geom) else $error("data size word wrong");
	property p_sel_level_zero;
		@(posedge sys_clk) disable iff (rst)
		(clk_en && acc_valid && acc_priv && !acc_write && acc_addr == cid_pkg::ADDR_SIZE_SELECT)
			|=> (acc_rdata[31:1] == 31'h0);
	endproperty
	a_sel_level_zero: assert property (p_sel_level_zero) else $error("level field set");
	property p_ro_hold;
		@(posedge sys_clk) disable iff (rst)
		(clk_en && acc_valid && acc_write && acc_addr != cid_pkg::ADDR_SIZE_SELECT)
			|=> $stable(st_reg.instr_sel);
	endproperty
	a_ro_hold: assert property (p_ro_hold) else $error("read-only write changed state");
	property p_type_fields;
		@(posedge sys_clk) disable iff (rst)
		(clk_en && acc_valid && acc_priv && !acc_write && acc_addr == cid_pkg::ADDR_TYPE_INFO)
			|=> (acc_rdata[31:29] == 3'h4 && acc_rdata[28] == 1'h0
			&& acc_rdata[27:24] == 4'h3 && acc_rdata[23:20] == 4'h0
			&& acc_rdata[19:16] == 4'h3 && acc_rdata[15:14] == 2'h3
			&& acc_rdata[13:4] == 10'h000 && acc_rdata[3:0] == 4'h3);
	endproperty
	a_type_fields: assert property (p_type_fields) else $error("type field wrong");
	property p_level_fields;
		@(posedge sys_clk) disable iff (rst)
		(clk_en && acc_valid && acc_priv && !acc_write && acc_addr == cid_pkg::ADDR_LEVEL_ID)
			|=> (acc_rdata[31:30] == 2'h0 && acc_rdata[23:2] == 22'h000000
			&& acc_rdata[1] == $past(dcache_present) && acc_rdata[0] == $past(icache_present));
	endproperty
	a_level_fields: assert property (p_level_fields) else $error("level field wrong");
	property p_instr_geom;
		@(posedge sys_clk) disable iff (rst)
		(st_reg.instr_sel && icache_present) |-> (size_word == 32'hF01FE009);
	endproperty
	a_instr_geom: assert property (p_instr_geom) else $error("instr size word wrong");
	c_fault: cover property (@(posedge sys_clk) disable iff (rst) bus_error_exception);
	c_instr_sel: cover property (@(posedge sys_clk) disable iff (rst) st_reg.instr_sel);
	c_size_read: cover property (@(posedge sys_clk) disable iff (rst)
		acc_valid && acc_priv && acc_addr == cid_pkg::ADDR_SIZE_ID);
endmodule // cid_regs

// File: rtl/cid_size_mux.sv
// Size word generator for the selected cache.
`timescale 1ns/1ps
module cid_size_mux (
	// Selection and configuration
	input wire logic instr_sel,
	input wire logic dcache_present,
	input wire logic icache_present,
	// Size word
	output logic [31:0] size_word
);
	always_comb begin
		if (instr_sel) begin
			size_word = icache_present ? {cid_pkg::SIZE_ATTR, cid_pkg::I_SETS_M1,
				cid_pkg::I_WAYS_M1, cid_pkg::LINE_CODE} : 32'h00000000;
		end else begin
			size_word = dcache_present ? {cid_pkg::SIZE_ATTR, cid_pkg::D_SETS_M1,
				cid_pkg::D_WAYS_M1, cid_pkg::LINE_CODE} : 32'h00000000;
		end
	end
endmodule // cid_size_mux

// File: verif/cache_identification_regs_tb_top.sv
// Self-checking testbench of the cache identification register bank.
`timescale 1ns/1ps
module cache_identification_regs_tb_top;
	logic sys_clk = 1'h0;
	logic rst = 1'h1;
	logic dcache_present = 1'h1;
	logic icache_present = 1'h1;
	logic acc_valid, acc_write, acc_priv, acc_done, bus_error_exception;
	logic [31:0] acc_addr, acc_wdata, acc_rdata;
	int mismatches = 0;
	int checks = 0;
	always #10 sys_clk = ~sys_clk;
	cid_regs i_cid_regs (.sys_clk(sys_clk), .rst(rst), .clk_en(1'h1),
		.dcache_present(dcache_present), .icache_present(icache_present),
		.acc_valid(acc_valid), .acc_write(acc_write), .acc_priv(acc_priv),
		.acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_done(acc_done),
		.bus_error_exception(bus_error_exception), .acc_rdata(acc_rdata));
	cid_core_model i_cid_core_model (.sys_clk(sys_clk), .acc_valid(acc_valid),
		.acc_write(acc_write), .acc_priv(acc_priv), .acc_addr(acc_addr),
		.acc_wdata(acc_wdata), .acc_done(acc_done),
		.bus_error_exception(bus_error_exception), .acc_rdata(acc_rdata));
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task xfer(input logic w, input logic p, input logic [31:0] a, input logic [31:0] d,
		input logic [31:0] m, input logic [31:0] e);
		logic [31:0] rd;
		logic dn;
		logic er;
		i_cid_core_model.access(w, p, a, d, rd, dn, er);
		chk({31'h0, dn}, {31'h0, p}); // Completion follows privilege.
		chk({31'h0, er}, {31'h0, ~p}); // Fault follows lack of privilege.
		chk(rd & m, e); // Masked read data.
	endtask
	task summarize;
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		#100000;
		mismatches++;
		summarize;
	end
	initial begin
		logic [2:0] lv;
		repeat (2) @(posedge sys_clk);
		rst <= 1'h0;
		// Selection resets to the data cache, so the size word shows data geometry.
		xfer(1'h0, 1'h1, cid_pkg::ADDR_SIZE_ID, 32'h0, 32'hFFFFFFFF, 32'hF01FE019); // Reset pick.
		for (int c = 0; c < 4; c++) begin
			@(posedge sys_clk);
			dcache_present <= c[1];
			icache_present <= c[0];
			lv = {2'h0, c[1] | c[0]};
			xfer(1'h0, 1'h1, cid_pkg::ADDR_LEVEL_ID, 32'h0, 32'hFFFFFFFF,
				{2'h0, lv, lv, 21'h0, 1'h0, c[1], c[0]}); // Level word.
			xfer(1'h1, 1'h1, cid_pkg::ADDR_SIZE_SELECT, 32'h0, 32'h0, 32'h0); // Pick data.
			xfer(1'h0, 1'h1, cid_pkg::ADDR_SIZE_ID, 32'h0, 32'hFFFFFFFF,
				c[1] ? 32'hF01FE019 : 32'h0); // Data size word.
			xfer(1'h1, 1'h1, cid_pkg::ADDR_SIZE_SELECT, 32'h1, 32'h0, 32'h0); // Pick instr.
			xfer(1'h0, 1'h1, cid_pkg::ADDR_SIZE_ID, 32'h0, 32'hFFFFFFFF,
				c[0] ? 32'hF01FE009 : 32'h0); // Instr size word.
		end
		$display("presence and size test done");
		xfer(1'h1, 1'h1, cid_pkg::ADDR_LEVEL_ID, 32'hFFFFFFFF, 32'h0, 32'h0); // Write RO.
		xfer(1'h1, 1'h1, cid_pkg::ADDR_TYPE_INFO, 32'h0, 32'h0, 32'h0); // Write RO.
		xfer(1'h0, 1'h1, cid_pkg::ADDR_LEVEL_ID, 32'h0, 32'hFFFFFFFF, 32'h09000003); // Kept.
		xfer(1'h0, 1'h1, cid_pkg::ADDR_TYPE_INFO, 32'h0, 32'hFFFFFFFF,
			32'h8303C003); // Type word.
		xfer(1'h0, 1'h1, 32'hE000ED88, 32'h0, 32'hFFFFFFFF, 32'h0); // Unmapped reads zero.
		$display("fixed word test done");
		xfer(1'h0, 1'h0, cid_pkg::ADDR_TYPE_INFO, 32'h0, 32'hFFFFFFFF, 32'h0); // No data.
		xfer(1'h1, 1'h0, cid_pkg::ADDR_SIZE_SELECT, 32'h0, 32'h0, 32'h0); // Write refused.
		xfer(1'h0, 1'h1, cid_pkg::ADDR_SIZE_SELECT, 32'h0, 32'hF, 32'h1); // Still one.
		xfer(1'h1, 1'h1, cid_pkg::ADDR_SIZE_SELECT, 32'hFFFFFFFE, 32'h0, 32'h0); // Level field.
		xfer(1'h0, 1'h1, cid_pkg::ADDR_SIZE_SELECT, 32'h0, 32'hF, 32'h0); // Reads zero.
		$display("privilege and select test done");
		summarize;
	end
endmodule // cache_identification_regs_tb_top

// File: verif/cid_core_model.sv
// Processor load and store path model that drives the bank's access port.
`timescale 1ns/1ps
module cid_core_model (
	// Clock
	sys_clk,
	// Access port
	acc_valid,
	acc_write,
	acc_priv,
	acc_addr,
	acc_wdata,
	// Answer
	acc_done,
	bus_error_exception,
	acc_rdata
);
	input wire logic sys_clk;
	output logic acc_valid = 1'h0;
	output logic acc_write = 1'h0;
	output logic acc_priv = 1'h0;
	output logic [31:0] acc_addr = 32'h0;
	output logic [31:0] acc_wdata = 32'h0;
	input wire logic acc_done;
	input wire logic bus_error_exception;
	input wire logic [31:0] acc_rdata;
	// One whole word per access; address and data are scrambled once released.
	task access(input logic w, input logic p, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic dn, output logic er);
		@(posedge sys_clk);
		acc_valid <= 1'h1;
		acc_write <= w;
		acc_priv <= p;
		acc_addr <= a;
		acc_wdata <= d;
		@(posedge sys_clk);
		acc_valid <= 1'h0;
		acc_addr <= ~a;
		acc_wdata <= ~d;
		@(posedge sys_clk);
		rd = acc_rdata;
		dn = acc_done;
		er = bus_error_exception;
	endtask
endmodule // cid_core_model
